// >>> wwd_defs.svh
// Purpose: named constants of the windowed supervisor
// Assumes: included by bare name
// Notes: byte offsets on a 32-bit Avalon-MM slave
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH
// ==========================================
// Register map
`define WWD_OFS_CTRL0 4'h0
`define WWD_OFS_CTRL1 4'h4
`define WWD_OFS_COUNT 4'h8
`define WWD_OFS_POWER_CONTROL_REG 4'hC
// ==========================================
// Field positions
`define WWD_C0_EN 0
`define WWD_C0_PS 5:1
`define WWD_C1_CS 6:4
`define WWD_C1_WIN 2:0
`define WWD_CNT_PRE 17:0
`define WWD_CNT_TMR 22:18
`define WWD_CNT_ARM 23
`define WWD_POWER_CONTROL_REG_FLAGS 3:0
// ==========================================
// Codes
`define WWD_MODE_ON 2'h3
`define WWD_MODE_AWAKE 2'h2
`define WWD_MODE_SOFT 2'h1
`define WWD_MODE_OFF 2'h0
`define WWD_PS_SW 5'h1F
`define WWD_PS_RESET 5'h0B
`define WWD_PS_MAX 5'h12
`define WWD_PS_MIN 5'h00
`define WWD_SEL_SW 3'h7
`define WWD_CS_LF 3'h0
`define WWD_CS_MF 3'h1
`define WWD_CS_SECONDARY_OSC 3'h2
`define WWD_TMR_LAST 5'h1F
// ==========================================
// Timing
`define WWD_CLK_HZ 50000000
`define WWD_LF_HZ 31000
`define WWD_MF_HZ 31250
`define WWD_SECONDARY_OSC_HZ 32000
`define WWD_DIV_W 11
`define WWD_DIV_LF 11'(`WWD_CLK_HZ / `WWD_LF_HZ - 1)
`define WWD_DIV_MF 11'(`WWD_CLK_HZ / `WWD_MF_HZ - 1)
`define WWD_DIV_SECONDARY_OSC 11'(`WWD_CLK_HZ / `WWD_SECONDARY_OSC_HZ - 1)
`endif

// >>> wwd_pkg.sv
// Purpose: types of the windowed supervisor
// Assumes: nothing
// Notes: configuration word travels as one struct
package wwd_pkg;
    // ==========================================
    // Non-volatile configuration
    typedef struct packed {
        logic [1:0] cfg_operating_mode;
        logic [4:0] cfg_period_select;
        logic [2:0] cfg_opening_size;
        logic [2:0] cfg_clock_source;
    } wwd_cfg_t;

    // Power-control flags, active low
    typedef struct packed {
        logic violation_flag_n;
        logic timeout_reset_flag_n;
        logic timeout_flag_n;
        logic powerdown_flag_n;
    } wwd_flags_t;
endpackage : wwd_pkg

// >>> wwd_counter.sv
// Purpose: 18-bit prescaler and 5-bit time-out counter
// Assumes: tick_i is a one-cycle enable, period_i at most 18
// Notes: time-out is a registered one-cycle pulse
`timescale 1ns/1ps
`include "wwd_defs.svh"
module wwd_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic [4:0] period_i,
    output logic [17:0] prescale_o,
    output logic [4:0] timer_o,
    output logic timeout_o
);
    logic [17:0] pre_reg;
    logic [4:0] timer_reg;
    logic to_reg;
    wire [17:0] mask = (18'h0_0001 << period_i) - 18'h0_0001;
    wire step = tick_i & ((pre_reg & mask) == mask);

    // ==========================================
    // Counting
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            pre_reg <= '0;
            timer_reg <= '0;
            to_reg <= 1'b0;
        end else begin
            if (tick_i) pre_reg <= pre_reg + 18'h0_0001;
            if (step) timer_reg <= timer_reg + 5'h01;
            to_reg <= step && (timer_reg == `WWD_TMR_LAST);
        end
    end

    assign prescale_o = pre_reg;
    assign timer_o = timer_reg;
    assign timeout_o = to_reg;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_STEP_ONE: assert property (tick_i && period_i == `WWD_PS_MIN && !clear_i
        |=> timer_reg == $past(timer_reg) + 5'h01) else $error("timer did not step");
    AST_TIMEOUT_AT_END: assert property (step && timer_reg == `WWD_TMR_LAST && !clear_i
        |=> to_reg && timer_reg == 5'h00) else $error("time-out missed at wrap");
endmodule : wwd_counter

// >>> wwd_supervisor.sv
// Purpose: windowed supervisory timer with Avalon-MM registers
// Assumes: all inputs synchronous to clk_i; kick_instruction_i is one cycle
// Notes: device_reset_o and wake_o are one-cycle pulses
// Operation
// - Mode 11: timer always runs, Sleep included, enable ignored.
// - Mode 10: runs awake, stops in Sleep, enable ignored.
// - Mode 01: software enable bit turns timer on or off.
// - Mode 00: timer always off, Sleep changes nothing.
// - Enable ignored in modes 1x and 00; resets 0, read/write.
// - Period code 0 is 1:32 ticks, each step doubles, up to code 18.
// - Period codes 19 to 31 behave as the minimum 1:32.
// - Period loads from config at reset; config 11111 loads 01011.
// - Period field writable only when period config is 11111.
// - Window size from config, or from software field when config is 111.
// - Window opening spans 12.5 to 100 percent of the period.
// - Windowed kick outside the open window causes a device reset.
// - Violation clears the violation flag; POR or firmware sets it.
// - Windowed kick needs a prior control-zero read, else violation.
// - Counter cleared on reset, kick, Sleep edges, disable, start-up, control-zero and control-one writes.
// - Oscillator failure clears counter; divider changes do not.
// - Time-out while awake and running resets the device.
// - Counting resumes in Sleep; held clear while start-up timer runs.
// - Time-out in Sleep wakes the device and clears status flags.
// - Tick from 31 kHz, 31.25 kHz or 32 kHz source, config or software chosen.
// - Window code 111 is full opening, each lower code 12.5 percent less.
// - Armed status bit is readable.
// - Clock codes: 000 31 kHz, 001 31.25 kHz, 010 32 kHz.
// - 18-bit prescale counter feeds time-out counter, readable.
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "wwd_defs.svh"
module wwd_supervisor (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic por_i,
    input wire wwd_pkg::wwd_cfg_t cfg_i,
    input wire logic sleep_i,
    input wire logic osc_startup_busy_i,
    input wire logic osc_fail_i,
    input wire logic kick_instruction_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic device_reset_o,
    output logic wake_o
);
    // ==========================================
    // Config or software field selection
    function automatic logic [2:0] pick3(input logic [2:0] cfg, input logic [2:0] sw);
        pick3 = (cfg == `WWD_SEL_SW) ? sw : cfg;
    endfunction : pick3

    // ==========================================
    // State
    logic soft_enable_reg;
    logic [4:0] period_reg;
    logic [2:0] clock_sel_reg;
    logic [2:0] window_reg;
    logic armed_reg;
    logic sleep_d_reg;
    logic waitreq_reg;
    logic [31:0] rdata_reg;
    logic reset_reg;
    logic wake_reg;
    wwd_pkg::wwd_flags_t flags_reg;
    logic [2:0] ticks;
    logic [17:0] prescale;
    logic [4:0] timer;
    logic timeout;

    // ==========================================
    // Bus decode
    wire req = avs_read_i | avs_write_i;
    wire accept = req & ~waitreq_reg;
    wire low_lane = avs_byteenable_i[0];
    wire hit_c0 = avs_address_i == `WWD_OFS_CTRL0;
    wire hit_c1 = avs_address_i == `WWD_OFS_CTRL1;
    wire hit_cnt = avs_address_i == `WWD_OFS_COUNT;
    wire hit_power_control_reg = avs_address_i == `WWD_OFS_POWER_CONTROL_REG;
    wire wr_c0 = accept & avs_write_i & hit_c0;
    wire wr_c1 = accept & avs_write_i & hit_c1;
    wire wr_power_control_reg = accept & avs_write_i & hit_power_control_reg & low_lane;
    wire arm_read = accept & avs_read_i & hit_c0;
    wire ps_writable = cfg_i.cfg_period_select == `WWD_PS_SW;
    wire cs_writable = cfg_i.cfg_clock_source == `WWD_SEL_SW;
    wire win_writable = cfg_i.cfg_opening_size == `WWD_SEL_SW;

    // ==========================================
    // Effective settings
    wire [2:0] cs_eff = pick3(cfg_i.cfg_clock_source, clock_sel_reg);
    wire [2:0] win_eff = pick3(cfg_i.cfg_opening_size, window_reg);
    wire [4:0] ps_eff = (period_reg > `WWD_PS_MAX) ? `WWD_PS_MIN : period_reg;
    wire sel_tick = (cs_eff == `WWD_CS_MF) ? ticks[1] :
                    (cs_eff == `WWD_CS_SECONDARY_OSC) ? ticks[2] : ticks[0];
    wire [1:0] mode = cfg_i.cfg_operating_mode;
    wire run = (mode == `WWD_MODE_ON) |
               ((mode == `WWD_MODE_AWAKE) & ~sleep_i) |
               ((mode == `WWD_MODE_SOFT) & soft_enable_reg);
    wire windowed = win_eff != `WWD_SEL_SW;
    // Elapsed eighths against closed eighths; code 111 has none closed
    wire win_open = timer[4:2] >= (3'h7 - win_eff);
    wire kick = kick_instruction_i & run;
    wire kick_bad = kick & windowed & ~(armed_reg & win_open);
    wire kick_ok = kick & ~kick_bad;
    wire sleep_edge = sleep_i ^ sleep_d_reg;
    wire to_awake = timeout & ~sleep_i;
    wire to_sleep = timeout & sleep_i;
    // Divider changes are outside this block, so they never clear it
    wire clear = kick_ok | sleep_edge | ~run | osc_startup_busy_i |
                 osc_fail_i | wr_c0 | wr_c1 | kick_bad;

    // ==========================================
    // Low-frequency tick dividers
    localparam logic [`WWD_DIV_W-1:0] DIVS [3] = '{`WWD_DIV_LF, `WWD_DIV_MF, `WWD_DIV_SECONDARY_OSC};
    genvar g;
    for (g = 0; g < 3; g++) begin : g_div
        logic [`WWD_DIV_W-1:0] cnt_reg;
        logic tick_reg;
        wire wrap = cnt_reg == DIVS[g];
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cnt_reg <= '0;
                tick_reg <= 1'b0;
            end else begin
                cnt_reg <= wrap ? '0 : cnt_reg + 11'h001;
                tick_reg <= wrap;
            end
        end
        assign ticks[g] = tick_reg;
    end

    // ==========================================
    // Counter
    wwd_counter u_counter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(clear),
        .tick_i(sel_tick),
        .period_i(ps_eff),
        .prescale_o(prescale),
        .timer_o(timer),
        .timeout_o(timeout)
    );

    // ==========================================
    // Control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_enable_reg <= 1'b0;
            period_reg <= ps_writable ? `WWD_PS_RESET : cfg_i.cfg_period_select;
            clock_sel_reg <= cs_writable ? `WWD_CS_LF : cfg_i.cfg_clock_source;
            window_reg <= cfg_i.cfg_opening_size;
        end else if (wr_c0 && low_lane) begin
            soft_enable_reg <= avs_writedata_i[`WWD_C0_EN];
            if (ps_writable) period_reg <= avs_writedata_i[`WWD_C0_PS];
        end else if (wr_c1 && low_lane) begin
            if (cs_writable) clock_sel_reg <= avs_writedata_i[`WWD_C1_CS];
            if (win_writable) window_reg <= avs_writedata_i[`WWD_C1_WIN];
        end
    end

    // Arming read wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) armed_reg <= 1'b0;
        else if (arm_read) armed_reg <= 1'b1;
        else if (clear) armed_reg <= 1'b0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_d_reg <= 1'b0;
            reset_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            sleep_d_reg <= sleep_i;
            reset_reg <= kick_bad | to_awake;
            wake_reg <= to_sleep;
        end
    end

    // ==========================================
    // Power-control flags: hardware clear beats firmware write
    wire [3:0] flag_clr = {kick_bad, timeout, to_sleep, to_sleep};
    for (g = 0; g < 4; g++) begin : g_flag
        always_ff @(posedge clk_i) begin
            if (rst_i) flags_reg[g] <= por_i ? 1'b1 : flags_reg[g];
            else if (flag_clr[g]) flags_reg[g] <= 1'b0;
            else if (wr_power_control_reg) flags_reg[g] <= avs_writedata_i[g];
        end
    end

    // ==========================================
    // Bus answer: one wait cycle, then the accept edge
    wire [31:0] rd_c0 = {26'h000_0000, period_reg, soft_enable_reg};
    wire [31:0] rd_c1 = {25'h000_0000, clock_sel_reg, 1'b0, window_reg};
    wire [31:0] rd_cnt = {8'h00, armed_reg, timer, prescale};
    wire [31:0] rd_power_control_reg = {28'h000_0000, flags_reg};
    wire [31:0] rd_mux = hit_c0 ? rd_c0 : hit_c1 ? rd_c1 :
                         hit_cnt ? rd_cnt : hit_power_control_reg ? rd_power_control_reg : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            waitreq_reg <= 1'b1;
            rdata_reg <= '0;
        end else begin
            waitreq_reg <= ~(req & waitreq_reg);
            if (avs_read_i && waitreq_reg) rdata_reg <= rd_mux;
        end
    end

    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = waitreq_reg;
    assign device_reset_o = reset_reg;
    assign wake_o = wake_reg;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_MODE_OFF: assert property (mode == `WWD_MODE_OFF
        |=> prescale == 18'h0_0000 && timer == 5'h00) else $error("counter ran in off mode");
    AST_AWAKE_ONLY: assert property (mode == `WWD_MODE_AWAKE && sleep_i
        |=> prescale == 18'h0_0000) else $error("counter ran in sleep");
    AST_SOFT_OFF: assert property (mode == `WWD_MODE_SOFT && !soft_enable_reg
        |=> prescale == 18'h0_0000) else $error("counter ran while soft disabled");
    AST_ALWAYS_ON: assert property (mode == `WWD_MODE_ON && sleep_i && sleep_d_reg && sel_tick
        && !osc_startup_busy_i && !osc_fail_i && !kick_instruction_i && !wr_c0 && !wr_c1
        |=> prescale == $past(prescale) + 18'h0_0001) else $error("always-on counter stalled");
    AST_UNARMED_KICK: assert property (kick && windowed && !armed_reg
        |=> device_reset_o && !flags_reg.violation_flag_n) else $error("unarmed kick not flagged");
    AST_CLOSED_KICK: assert property (kick && armed_reg && !win_open && windowed
        |=> device_reset_o ##1 !device_reset_o) else $error("closed-window kick missed");
    AST_TIMEOUT_AWAKE: assert property (timeout && !sleep_i
        |=> device_reset_o && !flags_reg.timeout_reset_flag_n && !wake_o) else $error("awake time-out");
    AST_TIMEOUT_SLEEP: assert property (timeout && sleep_i
        |=> wake_o && !device_reset_o && !flags_reg.timeout_flag_n && !flags_reg.powerdown_flag_n)
        else $error("sleep time-out did not wake");
    AST_PS_LOCKED: assert property (wr_c0 && !ps_writable
        |=> $stable(period_reg)) else $error("locked period changed");
    AST_ARM_DROP: assert property (clear && !arm_read |=> !armed_reg) else $error("armed survived clear");
    AST_BUS_ANSWER: assert property (req && waitreq_reg |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not one cycle");

    COV_VIOLATION: cover property (kick_bad ##1 device_reset_o);
    COV_GOOD_KICK: cover property (arm_read ##[1:1000] (kick_ok && windowed));
    COV_SLEEP_WAKE: cover property (to_sleep ##1 wake_o);
endmodule : wwd_supervisor

// >>> windowed_watchdog_timer_tb_top.sv
// Purpose: self-checking bench of the windowed supervisor
// Assumes: 50 MHz clock; configuration changes only under reset
// Notes: bus answers are awaited, never counted in advance
`timescale 1ns/1ps
`include "wwd_defs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module windowed_watchdog_timer_tb_top;
    // ==========================================
    // Signals
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic por_i = 1'b1;
    logic sleep_i = 1'b0;
    logic kick_instruction_i = 1'b0;
    logic osc_startup_busy_i = 1'b0;
    logic osc_fail_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [3:0] avs_byteenable_i = 4'hF;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic device_reset_o;
    logic wake_o;
    wwd_pkg::wwd_cfg_t cfg = '0;
    logic [31:0] rd;
    int err_count = 0;
    int n_checks = 0;
    int n_rst = 0;
    int n_wake = 0;
    int cyc = 0;

    wwd_supervisor dut (
        .clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .cfg_i(cfg), .sleep_i(sleep_i),
        .osc_startup_busy_i(osc_startup_busy_i), .osc_fail_i(osc_fail_i),
        .kick_instruction_i(kick_instruction_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .device_reset_o(device_reset_o), .wake_o(wake_o)
    );

    always #10 clk_i = ~clk_i;

    // Pulses are counted here so no test can miss a one-cycle output
    always @(posedge clk_i) begin
        cyc++;
        if (device_reset_o === 1'b1) n_rst++;
        if (wake_o === 1'b1) n_wake++;
        if (cyc == 90000) begin
            err_count++;
            print_verdict();
        end
    end

    // ==========================================
    // Tasks and expectations
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    task automatic do_reset(input wwd_pkg::wwd_cfg_t c);
        @(posedge clk_i);
        rst_i <= 1'b1;
        por_i <= 1'b1;
        sleep_i <= 1'b0;
        cfg <= c;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        por_i <= 1'b0;
    endtask : do_reset

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd, input logic [3:0] be);
        @(posedge clk_i);
        avs_address_i <= adr;
        avs_writedata_i <= wd;
        avs_byteenable_i <= be;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : bus

    task automatic rdr(input logic [3:0] adr);
        bus(1'b0, adr, 32'h0000_0000, 4'hF);
    endtask : rdr

    task automatic wrr(input logic [3:0] adr, input logic [31:0] wd);
        bus(1'b1, adr, wd, 4'hF);
    endtask : wrr

    task automatic kick;
        @(posedge clk_i);
        kick_instruction_i <= 1'b1;
        @(posedge clk_i);
        kick_instruction_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : kick

    function automatic logic [31:0] exp_c0(input logic [4:0] c, input logic en);
        return {26'h0, (c == `WWD_PS_SW) ? `WWD_PS_RESET : c, en};
    endfunction : exp_c0

    function automatic logic runs(input logic [1:0] m, input logic sl, input logic en);
        return m == `WWD_MODE_ON || (m == `WWD_MODE_AWAKE && !sl) || (m == `WWD_MODE_SOFT && en);
    endfunction : runs

    // ==========================================
    // Main sequence
    initial begin
        logic [31:0] v;
        logic [4:0] ps;
        logic [2:0] w;
        logic [2:0] cs;
        int r0;
        int t0;
        void'($urandom(32'hc0b1));
        do_reset('{2'h3, 5'h1F, 3'h7, 3'h7});
        rdr(`WWD_OFS_CTRL0); `CHK(rd, exp_c0(5'h1F, 1'b0))
        rdr(`WWD_OFS_CTRL1); `CHK(rd, 32'h0000_0007)
        rdr(`WWD_OFS_POWER_CONTROL_REG); `CHK(rd, 32'h0000_000F)
        rdr(4'h6); `CHK(rd, 32'h0000_0000)
        kick; `CHK(n_rst, 0)
        for (int i = 0; i < 6; i++) begin
            ps = 5'($urandom_range(31));
            w = 3'($urandom_range(7));
            cs = 3'($urandom_range(2));
            v = $urandom;
            wrr(`WWD_OFS_CTRL0, {v[31:6], ps, v[0]});
            rdr(`WWD_OFS_CTRL0); `CHK(rd, {26'h0, ps, v[0]})
            wrr(`WWD_OFS_CTRL1, {25'h0, cs, 1'b0, w});
            rdr(`WWD_OFS_CTRL1); `CHK(rd, {25'h0, cs, 1'b0, w})
        end
        bus(1'b1, `WWD_OFS_CTRL0, 32'h0000_0000, 4'hE);
        rdr(`WWD_OFS_CTRL0); `CHK(rd[5:0], {ps, v[0]})
        // Arming then kicking at once: the smallest window is still closed
        wrr(`WWD_OFS_CTRL1, 32'h0000_0000);
        rdr(`WWD_OFS_CTRL0);
        rdr(`WWD_OFS_COUNT); `CHK(rd[`WWD_CNT_ARM], 1'b1)
        r0 = n_rst;
        kick; `CHK(n_rst - r0, 1)
        rdr(`WWD_OFS_COUNT); `CHK(rd[`WWD_CNT_ARM], 1'b0)
        rdr(`WWD_OFS_POWER_CONTROL_REG); `CHK(rd[3], 1'b0)
        // Every mode, Sleep state and enable, kicked without arming
        for (int i = 0; i < 16; i++) begin
            do_reset('{i[3:2], 5'h1F, 3'h0, 3'h0});
            wrr(`WWD_OFS_CTRL0, 32'(i[0]));
            @(posedge clk_i);
            sleep_i <= i[1];
            repeat (3) @(posedge clk_i);
            r0 = n_rst;
            kick; `CHK(n_rst - r0, int'(runs(i[3:2], i[1], i[0])))
            rdr(`WWD_OFS_POWER_CONTROL_REG); `CHK(rd[3], !runs(i[3:2], i[1], i[0]))
        end
        wrr(`WWD_OFS_POWER_CONTROL_REG, 32'h0000_000F);
        rdr(`WWD_OFS_POWER_CONTROL_REG); `CHK(rd, 32'h0000_000F)
        // Locked period and clock fields
        ps = 5'($urandom_range(18));
        do_reset('{2'h1, ps, 3'h3, 3'h0});
        rdr(`WWD_OFS_CTRL0); `CHK(rd, exp_c0(ps, 1'b0))
        wrr(`WWD_OFS_CTRL0, {26'h0, ~ps, 1'b1});
        rdr(`WWD_OFS_CTRL0); `CHK(rd, exp_c0(ps, 1'b1))
        wrr(`WWD_OFS_CTRL1, 32'h0000_0074);
        rdr(`WWD_OFS_CTRL1); `CHK(rd, 32'h0000_0003)
        // Reserved period code, 1600 clocks per tick; window opens at timer 4
        do_reset('{2'h3, 5'h1F, 3'h7, 3'h7});
        ps = 5'($urandom_range(31, 19));
        wrr(`WWD_OFS_CTRL1, 32'h0000_0016);
        wrr(`WWD_OFS_CTRL0, {26'h0, ps, 1'b0});
        repeat (8000) @(posedge clk_i);
        rdr(`WWD_OFS_CTRL0);
        rdr(`WWD_OFS_COUNT); `CHK(rd[22:0] != 23'h0, 1'b1)
        `CHK(rd[`WWD_CNT_ARM], 1'b1)
        r0 = n_rst;
        kick; `CHK(n_rst - r0, 0)
        rdr(`WWD_OFS_COUNT); `CHK(rd[23:2], 22'h0)
        // Counting goes on in Sleep; an oscillator failure clears it
        sleep_i <= 1'b1;
        repeat (4000) @(posedge clk_i);
        rdr(`WWD_OFS_COUNT); `CHK(rd[22:2] != 21'h0, 1'b1)
        osc_fail_i <= 1'b1;
        @(posedge clk_i);
        osc_fail_i <= 1'b0;
        rdr(`WWD_OFS_COUNT); `CHK(rd[22:2], 21'h0)
        // Wake-up while the start-up timer runs holds the count at zero
        sleep_i <= 1'b0;
        osc_startup_busy_i <= 1'b1;
        repeat (4000) @(posedge clk_i);
        rdr(`WWD_OFS_COUNT); `CHK(rd[22:0], 23'h0)
        osc_startup_busy_i <= 1'b0;
        wrr(`WWD_OFS_CTRL1, 32'h0000_0017);
        t0 = cyc;
        rdr(`WWD_OFS_COUNT); `CHK(rd[22:2], 21'h0)
        r0 = n_rst;
        while (n_rst == r0) @(posedge clk_i);
        `CHK((cyc - t0) inside {[49500:52900]}, 1'b1)
        `CHK(n_wake, 0)
        print_verdict();
    end
endmodule : windowed_watchdog_timer_tb_top
